/* rtl/uart_regs.sv */
// Chosen here: the plain strobed port.
module uart_regs
	import uart_regs_pkg::*;
(
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic ce_i,
	input wire logic [ADDR_W-1:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [31:0] rdata_o,
	input wire logic serial_in_pin_i,
	output logic serial_out_pin_o,
	input wire logic dma_rx_end_i,
	input wire logic dma_tx_end_i,
	input wire logic dma_tx_buf_empty_i,
	input wire logic dma_rx_buf_full_i,
	output logic irq_o
);

	// ------------------------------------------------------------------
	// Decoding
	// ------------------------------------------------------------------
	function automatic logic parity_bit(input logic [2:0] mode, input logic [7:0] data);
		logic p;
		p = 1'b0;
		case (mode)
			PAR_EVEN: p = ^data;
			PAR_ODD: p = ~^data;
			PAR_MARK: p = 1'b1;
			default: p = 1'b0;
		endcase
		return p;
	endfunction

	// offset-only decode
	// The system decoder picks one of the two port bases, so only the offset arrives here.
	// Both instances are therefore built from this one module.
	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
		return a == off;
	endfunction

	logic [31:0] line_mode;
	logic [31:0] irq_mask;
	logic [CD_W-1:0] baud_cd;
	logic [CD_W-1:0] baud_cnt;
	logic baud_tick;
	logic rx_en;
	logic tx_en;
	rx_state_t rx_state;
	tx_state_t tx_state;
	logic [3:0] rx_sc;
	logic [3:0] rx_bitn;
	logic [7:0] rx_shift;
	logic rx_par;
	logic [7:0] rx_holding;
	logic rx_ready;
	logic overrun_err;
	logic frame_err;
	logic parity_err;
	logic [3:0] tx_sc;
	logic [3:0] tx_bitn;
	logic [7:0] tx_shift;
	logic [7:0] tx_hold;
	logic hold_valid;
	logic tx_line;

	wire logic wr_cmd = wr_i && hit(addr_i, OFF_COMMAND);
	wire logic wr_mode = wr_i && hit(addr_i, OFF_LINE_MODE);
	wire logic wr_ier = wr_i && hit(addr_i, OFF_IRQ_ENABLE_SET);
	wire logic wr_idr = wr_i && hit(addr_i, OFF_IRQ_ENABLE_CLEAR);
	wire logic wr_thr = wr_i && hit(addr_i, OFF_TX_HOLDING);
	wire logic wr_brg = wr_i && hit(addr_i, OFF_BAUD_DIVIDER);
	wire logic rd_rhr = rd_i && hit(addr_i, OFF_RX_HOLDING);

	wire logic cmd_rx_reset = wr_cmd && wdata_i[CMD_RX_RESET];
	wire logic cmd_tx_reset = wr_cmd && wdata_i[CMD_TX_RESET];
	wire logic cmd_rx_on = wr_cmd && wdata_i[CMD_RX_ON] && !wdata_i[CMD_RX_OFF];
	wire logic cmd_rx_off = wr_cmd && wdata_i[CMD_RX_OFF];
	wire logic cmd_tx_on = wr_cmd && wdata_i[CMD_TX_ON] && !wdata_i[CMD_TX_OFF];
	wire logic cmd_tx_off = wr_cmd && wdata_i[CMD_TX_OFF];
	wire logic cmd_err_clear = wr_cmd && wdata_i[CMD_ERR_CLEAR];

	wire logic [2:0] parity_type = line_mode[PAR_MSB:PAR_LSB];
	wire logic [1:0] channel_mode = line_mode[CHM_MSB:CHM_LSB];
	wire logic parity_on = parity_type != PAR_NONE && parity_type[2] == 1'b0;

	// Remote loopback keeps the receiver blind by feeding it an idle line.
	wire logic rx_line = (channel_mode == CHM_LOCAL) ? tx_line :
		(channel_mode == CHM_REMOTE) ? 1'b1 : serial_in_pin_i;

	wire logic next_serial_out = (channel_mode == CHM_NORMAL) ? tx_line :
		(channel_mode == CHM_LOCAL) ? 1'b1 : serial_in_pin_i;

	// ------------------------------------------------------------------
	// Baud generator: one tick per sixteenth of a bit, idle when divisor is zero
	// ------------------------------------------------------------------
	// A divisor of zero, the reset value, holds the receiver still; the transmitter still loads a character and then sits on its start bit.
	wire logic baud_wrap = baud_cnt >= baud_cd - 16'h0001;
	assign baud_tick = (baud_cd != 16'h0000) && baud_wrap;

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			baud_cnt <= 16'h0000;
		end else if (ce_i) begin
			baud_cnt <= (baud_tick || baud_cd == 16'h0000) ? 16'h0000 : baud_cnt + 16'h0001;
		end
	end

	// ------------------------------------------------------------------
	// Configuration registers
	// ------------------------------------------------------------------
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			line_mode <= MODE_RESET;
			baud_cd <= BAUD_RESET;
			irq_mask <= IRQ_MASK_RESET;
		end else if (ce_i) begin
			if (wr_mode) begin
				line_mode <= wdata_i & MODE_WMASK;
			end
			if (wr_brg) begin
				baud_cd <= wdata_i[CD_W-1:0];
			end
			irq_mask <= (irq_mask | (wr_ier ? wdata_i & STATUS_MASK : 32'h0000_0000)) &
				~(wr_idr ? wdata_i & STATUS_MASK : 32'h0000_0000);
		end
	end

	// ------------------------------------------------------------------
	// Receiver
	// ------------------------------------------------------------------
	wire logic rx_at_sample = baud_tick && rx_state == RX_SAMPLE && rx_sc == OVERSAMPLE_LAST;
	wire logic rx_last = parity_on ? (rx_bitn == DATA_BITS + 4'h1) : (rx_bitn == DATA_BITS);
	wire logic rx_done = rx_at_sample && rx_last;
	wire logic next_frame_err = !rx_line;
	wire logic next_parity_err = parity_on && (rx_par != parity_bit(parity_type, rx_shift));

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			rx_en <= 1'b0;
			rx_state <= RX_HUNT;
			rx_sc <= 4'h0;
			rx_bitn <= 4'h0;
			rx_shift <= 8'h00;
			rx_par <= 1'b0;
			rx_holding <= 8'h00;
		end else if (ce_i) begin
			if (cmd_rx_reset) begin
				rx_en <= 1'b0;
				rx_state <= RX_HUNT;
				rx_sc <= 4'h0;
				rx_bitn <= 4'h0;
			end else begin
				if (cmd_rx_off) begin
					rx_en <= 1'b0;
				end else if (cmd_rx_on) begin
					rx_en <= 1'b1;
				end
				case (rx_state)
					RX_HUNT: begin
						// Disabling the receiver while it hunts stops it at once.
						// A start bit counts only once it has lasted more than seven ticks.
						if (baud_tick && rx_en && !cmd_rx_off) begin
							if (rx_line) begin
								rx_sc <= 4'h0;
							end else if (rx_sc == START_LOW_MIN - 4'h1) begin
								rx_state <= RX_SAMPLE;
								rx_sc <= 4'h0;
								rx_bitn <= 4'h0;
							end else begin
								rx_sc <= rx_sc + 4'h1;
							end
						end
					end
					RX_SAMPLE: begin
						if (baud_tick) begin
							rx_sc <= rx_sc + 4'h1;
							if (rx_sc == OVERSAMPLE_LAST) begin
								rx_bitn <= rx_bitn + 4'h1;
								if (rx_bitn < DATA_BITS) begin
									rx_shift <= {rx_line, rx_shift[7:1]};
								end else if (!rx_last) begin
									rx_par <= rx_line;
								end
								if (rx_last) begin
									rx_state <= RX_HUNT;
									rx_sc <= 4'h0;
									rx_holding <= rx_shift;
								end
							end
						end
					end
					default: begin
						rx_state <= RX_HUNT;
					end
				endcase
			end
		end
	end

	// ------------------------------------------------------------------
	// Receive status flags; a set in the same cycle beats a read or error clear, but a receiver reset beats a set
	// ------------------------------------------------------------------
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			rx_ready <= 1'b0;
			overrun_err <= 1'b0;
			frame_err <= 1'b0;
			parity_err <= 1'b0;
		end else if (ce_i) begin
			if (rx_done && !cmd_rx_reset) begin
				rx_ready <= 1'b1;
			end else if (rd_rhr || cmd_rx_reset) begin
				rx_ready <= 1'b0;
			end
			if (rx_done && !cmd_rx_reset && rx_ready) begin
				overrun_err <= 1'b1;
			end else if (cmd_err_clear) begin
				overrun_err <= 1'b0;
			end
			if (rx_done && !cmd_rx_reset && next_frame_err) begin
				frame_err <= 1'b1;
			end else if (cmd_err_clear) begin
				frame_err <= 1'b0;
			end
			if (rx_done && !cmd_rx_reset && next_parity_err) begin
				parity_err <= 1'b1;
			end else if (cmd_err_clear) begin
				parity_err <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------------
	// Transmitter
	// ------------------------------------------------------------------
	wire logic [3:0] tx_stop_bitn = parity_on ? TX_STOP_PAR : TX_STOP_NOPAR;
	wire logic tx_bit_end = baud_tick && tx_state == TX_SHIFT && tx_sc == OVERSAMPLE_LAST;
	// Loading ignores the enable so that a disable lets queued characters drain.
	wire logic tx_load = tx_state == TX_IDLE && hold_valid;
	wire logic [3:0] tx_data_idx = tx_bitn - 4'h1;
	wire logic tx_bitval = (tx_bitn == 4'h0) ? 1'b0 :
		(tx_bitn <= DATA_BITS) ? tx_shift[tx_data_idx[2:0]] :
		(tx_bitn == tx_stop_bitn) ? 1'b1 : parity_bit(parity_type, tx_shift);

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			tx_en <= 1'b0;
			tx_state <= TX_IDLE;
			tx_sc <= 4'h0;
			tx_bitn <= 4'h0;
			tx_shift <= 8'h00;
			tx_hold <= 8'h00;
			hold_valid <= 1'b0;
			tx_line <= 1'b1;
		end else if (ce_i) begin
			if (cmd_tx_reset) begin
				tx_en <= 1'b0;
				tx_state <= TX_IDLE;
				tx_sc <= 4'h0;
				tx_bitn <= 4'h0;
				hold_valid <= 1'b0;
				tx_line <= 1'b1;
			end else begin
				// enable and disable; queued characters still drain
				if (cmd_tx_off) begin
					tx_en <= 1'b0;
				end else if (cmd_tx_on) begin
					tx_en <= 1'b1;
				end
				tx_line <= (tx_state == TX_SHIFT) ? tx_bitval : 1'b1;
				if (tx_load) begin
					tx_shift <= tx_hold;
					hold_valid <= 1'b0;
					tx_state <= TX_SHIFT;
					tx_sc <= 4'h0;
					tx_bitn <= 4'h0;
				end else if (tx_state == TX_SHIFT && baud_tick) begin
					tx_sc <= tx_sc + 4'h1;
					if (tx_bit_end) begin
						tx_bitn <= tx_bitn + 4'h1;
						if (tx_bitn == tx_stop_bitn) begin
							tx_state <= TX_IDLE;
						end
					end
				end
				// Writes while disabled are dropped.
				if (wr_thr && tx_en) begin
					tx_hold <= wdata_i[7:0];
					hold_valid <= 1'b1;
				end
			end
		end
	end

	// ------------------------------------------------------------------
	// Status word and read port
	// ------------------------------------------------------------------
	wire logic transmit_ready = tx_en && !hold_valid;
	// empty only when enabled and idle
	wire logic transmitter_empty = tx_en && !hold_valid && tx_state == TX_IDLE;

	logic [31:0] line_status;
	always_comb begin
		line_status = 32'h0000_0000;
		line_status[ST_RX_READY] = rx_ready;
		line_status[ST_TX_READY] = transmit_ready;
		line_status[ST_RX_DMA_END] = dma_rx_end_i;
		line_status[ST_TX_DMA_END] = dma_tx_end_i;
		line_status[ST_OVERRUN] = overrun_err;
		line_status[ST_FRAMING] = frame_err;
		line_status[ST_PARITY] = parity_err;
		line_status[ST_TX_EMPTY] = transmitter_empty;
		line_status[ST_TX_BUF_EMPTY] = dma_tx_buf_empty_i;
		line_status[ST_RX_BUF_FULL] = dma_rx_buf_full_i;
	end

	// register map; write-only, reserved and DMA offsets read zero
	wire logic [31:0] read_mux = hit(addr_i, OFF_LINE_MODE) ? line_mode :
		hit(addr_i, OFF_IRQ_MASK_VIEW) ? irq_mask :
		hit(addr_i, OFF_LINE_STATUS) ? line_status :
		hit(addr_i, OFF_RX_HOLDING) ? {24'h000000, rx_holding} :
		hit(addr_i, OFF_BAUD_DIVIDER) ? {16'h0000, baud_cd} : 32'h0000_0000;

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			rdata_o <= 32'h0000_0000;
			serial_out_pin_o <= 1'b1;
			irq_o <= 1'b0;
		end else if (ce_i) begin
			// register readback
			// Read data stand for one cycle after each read strobe cycle and then fall back to zero.
			rdata_o <= rd_i ? read_mux : 32'h0000_0000;
			serial_out_pin_o <= next_serial_out;
			irq_o <= |(line_status & irq_mask);
		end
	end

endmodule

/* rtl/uart_regs_pkg.sv */
package uart_regs_pkg;

	// ------------------------------------------------------------------
	// Register map (byte offsets within one port instance)
	// ------------------------------------------------------------------
	localparam int ADDR_W = 9;
	localparam logic [ADDR_W-1:0] OFF_COMMAND = 9'h000;
	localparam logic [ADDR_W-1:0] OFF_LINE_MODE = 9'h004;
	localparam logic [ADDR_W-1:0] OFF_IRQ_ENABLE_SET = 9'h008;
	localparam logic [ADDR_W-1:0] OFF_IRQ_ENABLE_CLEAR = 9'h00C;
	localparam logic [ADDR_W-1:0] OFF_IRQ_MASK_VIEW = 9'h010;
	localparam logic [ADDR_W-1:0] OFF_LINE_STATUS = 9'h014;
	localparam logic [ADDR_W-1:0] OFF_RX_HOLDING = 9'h018;
	localparam logic [ADDR_W-1:0] OFF_TX_HOLDING = 9'h01C;
	localparam logic [ADDR_W-1:0] OFF_BAUD_DIVIDER = 9'h020;
	localparam logic [ADDR_W-1:0] OFF_RESERVED_LAST = 9'h0FC;
	localparam logic [ADDR_W-1:0] OFF_DMA_FIRST = 9'h100;
	localparam logic [ADDR_W-1:0] OFF_DMA_LAST = 9'h128;

	// System addresses of the two port instances.
	localparam logic [31:0] PORT0_BASE = 32'h400E0600;
	localparam logic [31:0] PORT1_BASE = 32'h400E0800;

	// ------------------------------------------------------------------
	// Command register bits
	// ------------------------------------------------------------------
	localparam int CMD_RX_RESET = 2;
	localparam int CMD_TX_RESET = 3;
	localparam int CMD_RX_ON = 4;
	localparam int CMD_RX_OFF = 5;
	localparam int CMD_TX_ON = 6;
	localparam int CMD_TX_OFF = 7;
	localparam int CMD_ERR_CLEAR = 8;

	// ------------------------------------------------------------------
	// Mode register fields
	// ------------------------------------------------------------------
	localparam int PAR_LSB = 9;
	localparam int PAR_MSB = 11;
	localparam int CHM_LSB = 14;
	localparam int CHM_MSB = 15;
	localparam logic [31:0] MODE_RESET = 32'h0000_0000;
	localparam logic [31:0] MODE_WMASK = 32'h0000_CE00;
	localparam logic [2:0] PAR_EVEN = 3'h0;
	localparam logic [2:0] PAR_ODD = 3'h1;
	localparam logic [2:0] PAR_SPACE = 3'h2;
	localparam logic [2:0] PAR_MARK = 3'h3;
	localparam logic [2:0] PAR_NONE = 3'h4;
	localparam logic [1:0] CHM_NORMAL = 2'h0;
	localparam logic [1:0] CHM_ECHO = 2'h1;
	localparam logic [1:0] CHM_LOCAL = 2'h2;
	localparam logic [1:0] CHM_REMOTE = 2'h3;

	// ------------------------------------------------------------------
	// Status / interrupt mask bit layout
	// ------------------------------------------------------------------
	localparam int ST_RX_READY = 0;
	localparam int ST_TX_READY = 1;
	localparam int ST_RX_DMA_END = 3;
	localparam int ST_TX_DMA_END = 4;
	localparam int ST_OVERRUN = 5;
	localparam int ST_FRAMING = 6;
	localparam int ST_PARITY = 7;
	localparam int ST_TX_EMPTY = 9;
	localparam int ST_TX_BUF_EMPTY = 11;
	localparam int ST_RX_BUF_FULL = 12;
	localparam logic [31:0] STATUS_MASK = 32'h0000_1AFB;
	localparam logic [31:0] IRQ_MASK_RESET = 32'h0000_0000;

	// ------------------------------------------------------------------
	// Baud and character timing
	// ------------------------------------------------------------------
	localparam int CD_W = 16;
	localparam logic [15:0] BAUD_RESET = 16'h0000;
	localparam logic [3:0] OVERSAMPLE_LAST = 4'hF;
	localparam logic [3:0] START_LOW_MIN = 4'h8;
	localparam logic [3:0] DATA_BITS = 4'h8;
	localparam logic [3:0] TX_STOP_NOPAR = 4'h9;
	localparam logic [3:0] TX_STOP_PAR = 4'hA;

	typedef enum logic [0:0] {RX_HUNT, RX_SAMPLE} rx_state_t;
	typedef enum logic [0:0] {TX_IDLE, TX_SHIFT} tx_state_t;

endpackage

/* dv/uart_regs_props.sv */
// ------------------------------------------------------------------
// Port checker
// ------------------------------------------------------------------
module uart_regs_props
	import uart_regs_pkg::*;
(
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic ce_i,
	input wire logic [ADDR_W-1:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [31:0] rdata_o,
	input wire logic serial_in_pin_i,
	input wire logic serial_out_pin_o,
	input wire logic dma_rx_end_i,
	input wire logic dma_tx_end_i,
	input wire logic dma_tx_buf_empty_i,
	input wire logic dma_rx_buf_full_i,
	input wire logic irq_o
);
	logic [1:0] chm;
	wire rd_go = rd_i && ce_i;
	wire wr_go = wr_i && ce_i;
	wire wo_hit = addr_i == OFF_COMMAND || addr_i == OFF_IRQ_ENABLE_SET
		|| addr_i == OFF_IRQ_ENABLE_CLEAR || addr_i == OFF_TX_HOLDING;
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			chm <= CHM_NORMAL;
		end else if (wr_go && addr_i == OFF_LINE_MODE) begin
			chm <= wdata_i[CHM_MSB:CHM_LSB];
		end
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	a_wo_read_zero: assert property (rd_go && wo_hit |=> rdata_o == 32'h0)
		else $error("write-only register read nonzero");
	a_reserved_zero: assert property (rd_go && addr_i > OFF_BAUD_DIVIDER |=> rdata_o == 32'h0)
		else $error("reserved offset read nonzero");
	a_mode_fields: assert property (rd_go && addr_i == OFF_LINE_MODE |=>
		(rdata_o & ~MODE_WMASK) == 32'h0 && rdata_o[CHM_MSB:CHM_LSB] == $past(chm))
		else $error("mode readback wrong");
	a_status_dma: assert property (rd_go && addr_i == OFF_LINE_STATUS |=>
		rdata_o[ST_RX_DMA_END] == $past(dma_rx_end_i) && rdata_o[ST_TX_DMA_END] == $past(dma_tx_end_i)
		&& rdata_o[ST_TX_BUF_EMPTY] == $past(dma_tx_buf_empty_i)
		&& rdata_o[ST_RX_BUF_FULL] == $past(dma_rx_buf_full_i) && (rdata_o & ~STATUS_MASK) == 32'h0)
		else $error("status layout wrong");
	a_mask_layout: assert property (rd_go && addr_i == OFF_IRQ_MASK_VIEW |=>
		(rdata_o & ~STATUS_MASK) == 32'h0) else $error("mask reserved bit set");
	a_irq_all_off: assert property (wr_go && addr_i == OFF_IRQ_ENABLE_CLEAR
		&& (wdata_i & STATUS_MASK) == STATUS_MASK ##1 !(wr_i && addr_i == OFF_IRQ_ENABLE_SET)
		|=> !irq_o) else $error("interrupt with empty mask");
	a_tx_reset_idle: assert property (wr_go && addr_i == OFF_COMMAND && wdata_i[CMD_TX_RESET]
		&& chm == CHM_NORMAL ##1 (!wr_i)[*3] |-> serial_out_pin_o)
		else $error("line not idle after transmitter reset");
	a_echo_follow: assert property (chm[0] && $past(chm[0]) && $past(ce_i) |->
		serial_out_pin_o == $past(serial_in_pin_i)) else $error("echo output wrong");
	a_local_high: assert property (chm == CHM_LOCAL && $past(chm) == CHM_LOCAL |->
		serial_out_pin_o) else $error("local loopback output not idle");
	c_rx_ready: cover property (rd_go && addr_i == OFF_LINE_STATUS ##1 rdata_o[ST_RX_READY]);
	c_irq: cover property (irq_o);
	c_echo: cover property (chm == CHM_ECHO && !serial_in_pin_i);
endmodule
bind uart_regs uart_regs_props uart_regs_props_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
	.ce_i(ce_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
	.rdata_o(rdata_o), .serial_in_pin_i(serial_in_pin_i), .serial_out_pin_o(serial_out_pin_o),
	.dma_rx_end_i(dma_rx_end_i), .dma_tx_end_i(dma_tx_end_i),
	.dma_tx_buf_empty_i(dma_tx_buf_empty_i), .dma_rx_buf_full_i(dma_rx_buf_full_i),
	.irq_o(irq_o));

/* dv/uart_peer.sv */
// ------------------------------------------------------------------
// Remote serial device, sixteen clocks per bit
// ------------------------------------------------------------------
module uart_peer (
	input wire logic clk_i,
	input wire logic line_i,
	output logic line_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [8:0] rxq[$];
	logic [8:0] sh;
	initial line_o = 1'b1;
	task automatic bit_out(input logic v, input int n);
		line_o <= v;
		repeat (n) @(posedge clk_i);
	endtask
	// A low stop bit is cut short so the receiver cannot see a new start in it.
	task automatic send(input logic [7:0] d, input logic bad, input logic stop);
		@(posedge clk_i);
		bit_out(1'b0, 16);
		for (int i = 0; i < 8; i++) begin
			bit_out(d[i], 16);
		end
		bit_out(^d ^ bad, 16);
		bit_out(stop, stop ? 16 : 10);
		line_o <= 1'b1;
	endtask
	always begin
		@(negedge line_i);
		repeat (8) @(posedge clk_i);
		for (int i = 0; i < 9; i++) begin
			repeat (16) @(posedge clk_i);
			sh[i] = line_i;
		end
		repeat (16) @(posedge clk_i);
		rxq.push_back(sh);
	end
endmodule

/* dv/uart_regs_tb_top.sv */
// ------------------------------------------------------------------
// Register interface bench
// ------------------------------------------------------------------
module uart_regs_tb_top
	import uart_regs_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i = 1'b0, sys_rst_i = 1'b1, ce_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, rd_q = 1'b0;
	logic [ADDR_W-1:0] addr_i = '0;
	logic [31:0] wdata_i = '0, rdata_o, seed = 32'h87AB2192, v;
	logic serial_in_pin_i, serial_out_pin_o, irq_o;
	logic [3:0] dma_i = 4'h0;
	logic [ADDR_W-1:0] holes[8] = '{OFF_COMMAND, OFF_IRQ_ENABLE_SET, OFF_IRQ_ENABLE_CLEAR,
		OFF_TX_HOLDING, 9'h024, OFF_RESERVED_LAST, OFF_DMA_FIRST, OFF_DMA_LAST};
	logic [31:0] eq[$], mq[$];
	logic [8:0] tq[$];
	int errors = 0, total_checks = 0, cycles = 0;
	uart_regs uart_regs_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.serial_in_pin_i(serial_in_pin_i), .serial_out_pin_o(serial_out_pin_o),
		.dma_rx_end_i(dma_i[0]), .dma_tx_end_i(dma_i[1]), .dma_tx_buf_empty_i(dma_i[2]),
		.dma_rx_buf_full_i(dma_i[3]), .irq_o(irq_o));
	uart_peer uart_peer_i (.clk_i(clk_i), .line_i(serial_out_pin_o), .line_o(serial_in_pin_i));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [31:0] dmas();
		return {19'h0, dma_i[3], dma_i[2], 6'h0, dma_i[1], dma_i[0], 3'h0};
	endfunction
	function automatic logic [8:0] frame(input logic [2:0] p, input logic [7:0] d);
		case (p)
			PAR_EVEN: return {^d, d};
			PAR_ODD: return {~^d, d};
			PAR_SPACE: return {1'b0, d};
			default: return {1'b1, d};
		endcase
	endfunction
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		total_checks++;
		if (s !== e) begin
			errors++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic test_done();
		if (errors == 0 && total_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
		@(posedge clk_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= d;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] e, input logic [31:0] m);
		eq.push_back(e & m);
		mq.push_back(m);
		@(posedge clk_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge clk_i);
		rd_i <= 1'b0;
	endtask
	task automatic cut(input int c, input logic [7:0] d, input logic [31:0] e);
		fork
			uart_peer_i.send(d, 1'b0, 1'b1);
			begin
				repeat (60) @(posedge clk_i);
				wr(OFF_COMMAND, 32'h1 << c);
			end
		join
		rd(OFF_LINE_STATUS, e, 32'h1);
	endtask
	initial begin
		forever #4 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			test_done();
		end
		if (rd_q) begin
			chk("rdata", rdata_o & mq.pop_front(), eq.pop_front());
		end
		rd_q <= rd_i;
		if (uart_peer_i.rxq.size() > 0) begin
			chk("serial", 32'(uart_peer_i.rxq.pop_front()), 32'(tq.pop_front()));
		end
	end
	initial begin
		seed = lfsr(seed);
		dma_i = seed[3:0];
		repeat (12) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		rd(OFF_LINE_MODE, MODE_RESET, '1);
		rd(OFF_IRQ_MASK_VIEW, IRQ_MASK_RESET, '1);
		rd(OFF_RX_HOLDING, 32'h0, '1);
		rd(OFF_LINE_STATUS, dmas(), '1);
		wr(OFF_DMA_FIRST, '1);
		foreach (holes[i]) rd(holes[i], 32'h0, '1);
		for (int i = 0; i < 5; i++) begin
			seed = lfsr(seed);
			v = {seed[31:16], 2'(i), seed[13:12], 3'(i), seed[8:0]};
			wr(OFF_LINE_MODE, v);
			rd(OFF_LINE_MODE, v, MODE_WMASK);
		end
		seed = lfsr(seed);
		wr(OFF_IRQ_ENABLE_SET, seed);
		v = seed & STATUS_MASK;
		rd(OFF_IRQ_MASK_VIEW, v, '1);
		seed = lfsr(seed);
		wr(OFF_IRQ_ENABLE_CLEAR, seed);
		rd(OFF_IRQ_MASK_VIEW, v & ~seed, '1);
		wr(OFF_IRQ_ENABLE_CLEAR, STATUS_MASK);
		rd(OFF_IRQ_MASK_VIEW, 32'h0, '1);
		wr(OFF_BAUD_DIVIDER, 32'h0000_0001);
		rd(OFF_BAUD_DIVIDER, 32'h0000_0001, '1);
		@(posedge clk_i);
		ce_i <= 1'b0;
		wr(OFF_BAUD_DIVIDER, 32'h0000_0005);
		ce_i <= 1'b1;
		rd(OFF_BAUD_DIVIDER, 32'h0000_0001, '1);
		wr(OFF_LINE_MODE, 32'h0);
		wr(OFF_COMMAND, 32'h0000_00C0);
		rd(OFF_LINE_STATUS, 32'h0, 32'h0000_0202);
		wr(OFF_COMMAND, 32'h0000_0050);
		rd(OFF_LINE_STATUS, 32'h0000_0202 | dmas(), '1);
		for (int p = 0; p < 5; p++) begin
			seed = lfsr(seed);
			wr(OFF_LINE_MODE, 32'(p) << PAR_LSB);
			tq.push_back(frame(3'(p), seed[7:0]));
			wr(OFF_TX_HOLDING, seed);
			repeat (200) @(posedge clk_i);
		end
		wr(OFF_LINE_MODE, 32'h0);
		tq.push_back(frame(PAR_EVEN, 8'h81));
		tq.push_back(frame(PAR_EVEN, 8'h7E));
		wr(OFF_TX_HOLDING, 32'h81);
		wr(OFF_TX_HOLDING, 32'h7E);
		wr(OFF_COMMAND, 32'h1 << CMD_TX_OFF);
		repeat (420) @(posedge clk_i);
		rd(OFF_LINE_STATUS, 32'h0, 32'h0000_0202);
		wr(OFF_COMMAND, 32'h1 << CMD_TX_RESET);
		repeat (4) @(posedge clk_i);
		uart_peer_i.send(8'hA5, 1'b0, 1'b1);
		rd(OFF_LINE_STATUS, 32'h1, 32'h0000_00E1);
		rd(OFF_RX_HOLDING, 32'hA5, '1);
		rd(OFF_LINE_STATUS, 32'h0, 32'h1);
		uart_peer_i.send(8'h3C, 1'b0, 1'b1);
		uart_peer_i.send(8'hC3, 1'b0, 1'b1);
		rd(OFF_LINE_STATUS, 32'h21, 32'h0000_00E1);
		rd(OFF_RX_HOLDING, 32'hC3, '1);
		uart_peer_i.send(8'h0F, 1'b1, 1'b1);
		rd(OFF_RX_HOLDING, 32'h0F, '1);
		uart_peer_i.send(8'h55, 1'b0, 1'b0);
		rd(OFF_LINE_STATUS, 32'hE1, 32'h0000_00E1);
		wr(OFF_COMMAND, 32'h1 << CMD_ERR_CLEAR);
		rd(OFF_LINE_STATUS, 32'h01, 32'h0000_00E1);
		wr(OFF_IRQ_ENABLE_SET, 32'h1 << ST_RX_READY);
		repeat (2) @(posedge clk_i);
		chk("irq", 32'(irq_o), 32'h1);
		wr(OFF_IRQ_ENABLE_CLEAR, 32'h1 << ST_RX_READY);
		repeat (2) @(posedge clk_i);
		chk("irq", 32'(irq_o), 32'h0);
		rd(OFF_RX_HOLDING, 32'h55, '1);
		cut(CMD_RX_OFF, 8'h66, 32'h1);
		rd(OFF_RX_HOLDING, 32'h66, '1);
		uart_peer_i.send(8'h77, 1'b0, 1'b1);
		rd(OFF_LINE_STATUS, 32'h0, 32'h1);
		wr(OFF_COMMAND, 32'h1 << CMD_RX_ON);
		cut(CMD_RX_RESET, 8'h11, 32'h0);
		wr(OFF_LINE_MODE, 32'(CHM_ECHO) << CHM_LSB);
		tq.push_back(frame(PAR_EVEN, 8'h5A));
		uart_peer_i.send(8'h5A, 1'b0, 1'b1);
		repeat (40) @(posedge clk_i);
		wr(OFF_LINE_MODE, 32'h0);
		repeat (4) @(posedge clk_i);
		chk("tx_pending", 32'(tq.size()), 32'h0);
		test_done();
	end
endmodule
